// ### dv/host_model.sv
/* host side of the register port: one-cycle strobes.
   assumes calls start 10 ns after a rising edge. */
module host_model
(
  input wire logic clk_sys_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_ack_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_seen;
  initial begin
    reg_wr_out = 0;
    reg_rd_out = 0;
    reg_addr_out = 8'h5A;
    reg_wdata_out = 8'hA5;
  end
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    reg_wr_out = w;
    reg_rd_out = !w;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge clk_sys_in);
    #1 q = reg_rdata_in;
    ack_seen = reg_ack_in;
    // one-cycle strobe: drop it, then let an edge pass before the next call
    #9;
    reg_wr_out = 0;
    reg_rd_out = 0;
    reg_addr_out = ~reg_addr_out;
    reg_wdata_out = ~reg_wdata_out;
    @(posedge clk_sys_in);
    #10;
  endtask : xfer
  // released lines do not keep their last value
  task automatic idle;
    reg_wr_out = 0;
    reg_rd_out = 0;
    reg_addr_out = ~reg_addr_out;
    reg_wdata_out = ~reg_wdata_out;
  endtask : idle
endmodule : host_model

// ### dv/seq_regs_properties.sv
/* checker for the sequencing register block.
   assumes it is bound onto the block's own ports. */
module seq_regs_checker
  import seq_regs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hardware_reset_pin_n_in,
  input wire logic output_undervoltage_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic buck_standby_request_out,
  input wire logic sleep_request_out,
  input wire logic soft_reset_out,
  input wire logic defaults_not_loaded_flag_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire logic stb = reg_wr_in | reg_rd_in;
  wire logic rd8 = reg_rd_in & !reg_wr_in & (reg_addr_in == OFS_MODE_CTRL);
  wire logic hit = reg_addr_in inside {OFS_SUPPLY_STATUS, OFS_FAULT_MASK, OFS_MODE_CTRL};
  sequence s_mode_wr;
    reg_wr_in && reg_addr_in == OFS_MODE_CTRL;
  endsequence
  // ==========================================================
  // properties
  chk_ack_follows: assert property (stb |=> reg_ack_out)
    else $error("ack missing");
  chk_ack_quiet: assert property (!stb |=> !reg_ack_out)
    else $error("stray ack");
  chk_standby_write: assert property (s_mode_wr |=>
    buck_standby_request_out == $past(reg_wdata_in[BIT_STANDBY])) else $error("standby bit");
  chk_sleep_pulse: assert property (s_mode_wr ##0 reg_wdata_in[BIT_SLEEP] |=>
    sleep_request_out ##1 (!sleep_request_out || $past(reg_wr_in))) else $error("sleep pulse");
  chk_reset_pulse: assert property (s_mode_wr ##0 reg_wdata_in[BIT_SOFT_RESET] |=>
    soft_reset_out ##1 (!soft_reset_out || $past(reg_wr_in))) else $error("reset pulse");
  chk_unused_zero: assert property (rd8 |=> (reg_rdata_out & ~MODE_CTRL_USED) == 8'h00)
    else $error("unused bits set");
  chk_unmapped_zero: assert property (reg_rd_in && !hit |=> reg_rdata_out == 8'h00)
    else $error("unmapped read");
  chk_pin_clears: assert property ((!hardware_reset_pin_n_in) [*8] |->
    !defaults_not_loaded_flag_out) else $error("flag kept on pin");
  chk_uv_clears: assert property (output_undervoltage_in [*8] |->
    !defaults_not_loaded_flag_out) else $error("flag kept on uv");
endmodule : seq_regs_checker
bind supply_fault_sequencing_regs seq_regs_checker seq_regs_checker_inst (.clk_sys_in,
  .sys_rst_in, .hardware_reset_pin_n_in, .output_undervoltage_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .buck_standby_request_out,
  .sleep_request_out, .soft_reset_out, .defaults_not_loaded_flag_out);

// ### dv/supply_fault_sequencing_regs_bench.sv
/* self-checking bench for the sequencing register block.
   assumes the host model and the bound checker. */
module supply_fault_sequencing_regs_bench import seq_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, sys_rst_in = 1, pin_n = 1, uv = 0, normal = 0;
  logic wr, rd, ack, sby, slp, srst, osc, nld, ev, vld;
  logic [7:0] addr, wdata, rdata, q, sup = 8'h00;
  logic [3:0] flg = 4'h0, iflg;
  int bad_count = 0, samples_checked = 0, cycles = 0, evs = 0, slps = 0, srsts = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (ev === 1'b1) evs++;
    if (slp === 1'b1) slps++;
    if (srst === 1'b1) srsts++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  supply_fault_sequencing_regs supply_fault_sequencing_regs_inst (.clk_sys_in, .sys_rst_in,
    .hardware_reset_pin_n_in(pin_n), .output_undervoltage_in(uv), .normal_mode_in(normal),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_ack_out(ack), .buck_one_fault_in(sup[7]),
    .buck_two_fault_in(sup[6]), .led_boost_driver_ovp_in(sup[5]), .linear_reg_fault_in(sup[4:0]),
    .converter_result_high_in(flg[0]), .converter_result_low_in(flg[1]),
    .analog_input_one_open_in(flg[2]), .thermal_fault_in(flg[3]), .buck_standby_request_out(sby),
    .sleep_request_out(slp), .soft_reset_out(srst), .led_driver_low_freq_osc_out(osc),
    .defaults_not_loaded_flag_out(nld), .supply_fault_event_out(ev), .status_valid_out(vld),
    .internal_flags_out(iflg));
  host_model host_model_inst (.clk_sys_in, .reg_rdata_in(rdata), .reg_ack_in(ack),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
  task automatic chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #10;
  endtask : cyc
  task automatic wr8(input logic [7:0] a, d);
    host_model_inst.xfer(1, a, d, q);
  endtask : wr8
  task automatic rdc(input logic [7:0] a, e);
    host_model_inst.xfer(0, a, 8'h00, q);
    chk(host_model_inst.ack_seen, 1);
    chk(q, e);
  endtask : rdc
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(2);
    sys_rst_in = 0;
    normal = 1;
    cyc(8);
    chk(vld, 1);
    rdc(OFS_SUPPLY_STATUS, 8'h00);
    rdc(OFS_FAULT_MASK, 8'h00);
    rdc(8'h05, 8'h00);
    wr8(OFS_MODE_CTRL, 8'hFF);
    chk({sby, slp, srst, osc, nld}, 8'h13);
    chk(slps, 1);
    chk(srsts, 1);
    rdc(OFS_MODE_CTRL, 8'h8A);
    chk({slp, srst}, 8'h00);
    wr8(OFS_MODE_CTRL, 8'h00);
    host_model_inst.idle();
    cyc(1);
    chk(sby, 0);
    $display("mode control test done");
    evs = 0;
    for (int i = 0; i < 8; i++) begin
      sup = 8'h01 << i;
      cyc(8);
      rdc(OFS_SUPPLY_STATUS, 8'h01 << i);
      host_model_inst.idle();
      sup = 8'h00;
      cyc(8);
    end
    chk(evs, 16);
    wr8(OFS_FAULT_MASK, 8'hFF);
    rdc(OFS_FAULT_MASK, 8'hFF);
    evs = 0;
    sup = 8'hFF;
    cyc(8);
    wr8(OFS_SUPPLY_STATUS, 8'h00);
    rdc(OFS_SUPPLY_STATUS, 8'hFF);
    host_model_inst.idle();
    sup = 8'h00;
    flg = 4'hA;
    cyc(8);
    chk(evs, 0);
    chk(iflg, 4'hA);
    $display("status and mask test done");
    for (int k = 0; k < 2; k++) begin
      // host marks registers as initialised on entering normal mode
      wr8(OFS_MODE_CTRL, 8'h02);
      host_model_inst.idle();
      cyc(1);
      chk(nld, 1);
      pin_n = k;
      uv = k;
      normal = 0;
      cyc(10);
      chk({nld, vld}, 8'h00);
      pin_n = 1;
      uv = 0;
      normal = 1;
      cyc(8);
      rdc(OFS_MODE_CTRL, 8'h00);
      host_model_inst.idle();
      cyc(1);
    end
    $display("defaults load test done");
    print_verdict();
  end
endmodule : supply_fault_sequencing_regs_bench

// ### verilog/pin_sync.sv
/*
  three-stage synchroniser with agreement filter for a bus of pins.
  assumes inputs are asynchronous to clk_sys_in.
*/
module pin_sync
  import seq_regs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] sync_nxt;

  // ==========================================================
  // a change counts once stages two and three agree
  assign agree = ~(s2_r ^ s3_r);
  assign sync_nxt = (agree & s3_r) | (~agree & sync_r);
  assign sync_out = sync_r;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      sync_r <= INIT;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      sync_r <= sync_nxt;
    end
  end

endmodule : pin_sync

// ### verilog/seq_regs_pkg.sv
/*
  package for the sequencing register block: offsets, bit positions, reset values.
  assumes a byte-wide register port driven by the i2c slave front end.
*/
package seq_regs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h02;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h07;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h08;

  // ==========================================================
  // mode control bit positions
  localparam int BIT_STANDBY = 7;
  localparam int BIT_SLEEP = 6;
  localparam int BIT_LED_OSC = 3;
  localparam int BIT_NOT_LOADED = 1;
  localparam int BIT_SOFT_RESET = 0;

  // bits that hold storage in the mode control register
  localparam logic [7:0] MODE_CTRL_USED = 8'hCB;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] FAULT_MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // internal status flag positions
  localparam int FLAG_CONV_HIGH = 0;
  localparam int FLAG_CONV_LOW = 1;
  localparam int FLAG_ANALOG_OPEN = 2;
  localparam int FLAG_THERMAL = 3;
  localparam int FLAG_WIDTH = 4;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

endpackage : seq_regs_pkg

// ### verilog/supply_fault_sequencing_regs.sv
/*
  mode/reset control, supply status and supply fault mask registers of the
  power sequencing controller, with supply fault event generation.
  assumes an i2c slave front end presents byte writes and reads as a
  one-cycle strobe with an 8-bit offset, on clk_sys_in.
*/
// What this block does
// R01: mode control readable, writable; few bits sequence
// R02: standby bit puts both bucks standby
// R03: sleep bit requests sleep, self-clears
// R04: soft reset bit resets, self-clears
// R05: host sets not-loaded flag entering normal
// R06: defaults load clears not-loaded flag
// R07: status register read-only, shows live supplies
// R08: status bit order bucks, led, linears
// R09: mask register per supply, one masks
// R10: unmasked status toggle raises fault event
// R11: status valid only after normal mode
// R12: internal flags kept without register bits
// R13: unused mode bits read zero
// R14: writes to status register ignored
module supply_fault_sequencing_regs
  import seq_regs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hardware_reset_pin_n_in,
  input wire logic output_undervoltage_in,
  input wire logic normal_mode_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic buck_one_fault_in,
  input wire logic buck_two_fault_in,
  input wire logic led_boost_driver_ovp_in,
  input wire logic [4:0] linear_reg_fault_in,
  input wire logic converter_result_high_in,
  input wire logic converter_result_low_in,
  input wire logic analog_input_one_open_in,
  input wire logic thermal_fault_in,
  output logic buck_standby_request_out,
  output logic sleep_request_out,
  output logic soft_reset_out,
  output logic led_driver_low_freq_osc_out,
  output logic defaults_not_loaded_flag_out,
  output logic supply_fault_event_out,
  output logic status_valid_out,
  output logic [FLAG_WIDTH-1:0] internal_flags_out
);

  // ==========================================================
  // declarations
  logic [7:0] mode_ctrl_r;
  logic [7:0] mode_ctrl_nxt;
  logic [7:0] fault_mask_r;
  logic [7:0] fault_mask_nxt;
  logic [7:0] status_prev_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic ack_r;
  logic fault_event_r;
  logic valid_r;
  logic [FLAG_WIDTH-1:0] flags_r;
  logic [7:0] status_raw;
  logic [7:0] supply_status;
  logic [1:0] load_pins_raw;
  logic [1:0] load_pins;
  logic [FLAG_WIDTH-1:0] flags_raw;
  logic [FLAG_WIDTH-1:0] flags_sync;
  logic load_defaults;
  logic wr_mode;
  logic wr_mask;
  logic rd_hit;
  logic [7:0] status_toggle;

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    addr_is = (addr == ofs);
  endfunction : addr_is

  // ==========================================================
  // pin synchronisers
  // R08 status bit order
  assign status_raw = {buck_one_fault_in, buck_two_fault_in, led_boost_driver_ovp_in,
                       linear_reg_fault_in};
  assign load_pins_raw = {~hardware_reset_pin_n_in, output_undervoltage_in};
  assign flags_raw = {thermal_fault_in, analog_input_one_open_in,
                      converter_result_low_in, converter_result_high_in};

  pin_sync #(
    .WIDTH(8),
    .INIT(STATUS_RESET)
  ) u_status_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(status_raw),
    .sync_out(supply_status)
  );

  pin_sync #(
    .WIDTH(2),
    .INIT(2'b00)
  ) u_load_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(load_pins_raw),
    .sync_out(load_pins)
  );

  pin_sync #(
    .WIDTH(FLAG_WIDTH),
    .INIT('0)
  ) u_flag_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(flags_raw),
    .sync_out(flags_sync)
  );

  // ==========================================================
  // decode
  // R06 defaults load on undervoltage or reset pin low
  assign load_defaults = |load_pins;
  assign wr_mode = reg_wr_in & addr_is(reg_addr_in, OFS_MODE_CTRL);
  assign wr_mask = reg_wr_in & addr_is(reg_addr_in, OFS_FAULT_MASK);
  assign rd_hit = reg_rd_in;

  // ==========================================================
  // mode control next value
  always_comb begin
    mode_ctrl_nxt = mode_ctrl_r;
    // R03 sleep self-clears
    mode_ctrl_nxt[BIT_SLEEP] = 1'b0;
    // R04 soft reset self-clears
    mode_ctrl_nxt[BIT_SOFT_RESET] = 1'b0;
    if (wr_mode) begin
      // R01 writable; R13 unused bits dropped; R05 host sets flag
      mode_ctrl_nxt = reg_wdata_in & MODE_CTRL_USED;
    end
  end

  // R09 mask register read/write
  assign fault_mask_nxt = wr_mask ? reg_wdata_in : fault_mask_r;

  // ==========================================================
  // read mux
  // R14 status has no write path; R07 read shows live status
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_hit) begin
      if (addr_is(reg_addr_in, OFS_SUPPLY_STATUS)) begin
        rdata_nxt = supply_status;
      end else if (addr_is(reg_addr_in, OFS_FAULT_MASK)) begin
        rdata_nxt = fault_mask_r;
      end else if (addr_is(reg_addr_in, OFS_MODE_CTRL)) begin
        // R13 unused bits read zero
        rdata_nxt = mode_ctrl_r & MODE_CTRL_USED;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // ==========================================================
  // R10 unmasked toggle detection
  assign status_toggle = (supply_status ^ status_prev_r) & ~fault_mask_r;

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || load_defaults) begin
      // R06 defaults clear not-loaded flag
      mode_ctrl_r <= MODE_CTRL_RESET;
      fault_mask_r <= FAULT_MASK_RESET;
    end else begin
      mode_ctrl_r <= mode_ctrl_nxt;
      fault_mask_r <= fault_mask_nxt;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      status_prev_r <= STATUS_RESET;
      fault_event_r <= 1'b0;
      valid_r <= 1'b0;
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
      flags_r <= '0;
    end else begin
      status_prev_r <= supply_status;
      // R10 one-cycle fault event
      fault_event_r <= |status_toggle;
      // R11 valid once normal mode reached
      valid_r <= (valid_r | normal_mode_in) & ~load_defaults;
      rdata_r <= rdata_nxt;
      ack_r <= reg_wr_in | reg_rd_in;
      // R12 internal flags only
      flags_r <= flags_sync;
    end
  end

  // ==========================================================
  // outputs
  // R02 standby to both bucks
  assign buck_standby_request_out = mode_ctrl_r[BIT_STANDBY];
  assign sleep_request_out = mode_ctrl_r[BIT_SLEEP];
  assign soft_reset_out = mode_ctrl_r[BIT_SOFT_RESET];
  assign led_driver_low_freq_osc_out = mode_ctrl_r[BIT_LED_OSC];
  assign defaults_not_loaded_flag_out = mode_ctrl_r[BIT_NOT_LOADED];
  assign supply_fault_event_out = fault_event_r;
  assign status_valid_out = valid_r;
  assign internal_flags_out = flags_r;
  assign reg_rdata_out = rdata_r;
  assign reg_ack_out = ack_r;

endmodule : supply_fault_sequencing_regs
